// [rtl/io_switch_matrix_map.svh]
// Constants for the IO switch matrix: pad indices, config codes, reset values.
// Assumes inclusion by the package, the design modules and the bench.
`ifndef IO_SWITCH_MATRIX_MAP_SVH
`define IO_SWITCH_MATRIX_MAP_SVH

`define PAD_COUNT          12
`define PAD_HOST_DOUT      0
`define PAD_HOST_DIN       1
`define PAD_HOST_CLK       2
`define PAD_HOST_SEL       3
`define PAD_HOST_INT       4
`define PAD_FIRST_MUXED    5
`define CFG_CODE_A         2'h0
`define CFG_CODE_B         2'h1
`define CFG_CODE_C         2'h2
`define CFG_CODE_D         2'h3
`define PAD_OE_RESET       12'h000
`define HOST_PAD_OE        12'h011

`endif

// [rtl/io_switch_matrix_pkg.sv]
// Types shared by the IO switch matrix modules.
// Assumes the map header sits beside it on the include path.
`include "io_switch_matrix_map.svh"

package io_switch_matrix_pkg;

  typedef enum logic [2:0] {
    ROUTE_DEFAULT,
    ROUTE_A,
    ROUTE_B,
    ROUTE_C,
    ROUTE_D
  } route_type;

  // Functional outputs toward the pads
  typedef struct packed {
    logic host_dout;
    logic host_int;
    logic audio_dout;
    logic debug_txd;
    logic ext_receive_enable;
    logic ext_amp_enable;
  } func_out_type;

  // Functional inputs taken from the pads
  typedef struct packed {
    logic host_din;
    logic host_clk;
    logic host_link_select_n;
    logic host_service_request_in;
    logic audio_din;
    logic debug_rxd;
    logic audio_bit_clock;
    logic audio_word_select;
  } func_in_type;

  // Pad drive group
  typedef struct packed {
    logic [`PAD_COUNT-1:0] out;
    logic [`PAD_COUNT-1:0] oe;
  } pad_drive_type;

endpackage

// [rtl/pad_route_table.sv]
// Combinational route table: picks pad drive and input sources per route.
// Assumes the caller registers whatever it needs.
`timescale 1ns/1ps
`include "io_switch_matrix_map.svh"

module pad_route_table (
  // Route select
  input  wire io_switch_matrix_pkg::route_type    route_in,
  // Functional outputs
  input  wire io_switch_matrix_pkg::func_out_type func_out_in,
  // Pad drive
  output io_switch_matrix_pkg::pad_drive_type     drive_out,
  // Input source selects: 0 none, else pad index
  output logic [3:0]                              audio_din_pad_out,
  output logic [3:0]                              debug_rxd_pad_out,
  output logic                                    audio_clk_valid_out
);
  import io_switch_matrix_pkg::*;

  // Pad table by route
  always_comb begin
    drive_out                    = '0;
    audio_din_pad_out            = 4'h0;
    debug_rxd_pad_out            = 4'h0;
    audio_clk_valid_out          = 1'b0;
    drive_out.out[`PAD_HOST_DOUT] = func_out_in.host_dout;
    drive_out.out[`PAD_HOST_INT]  = func_out_in.host_int;
    drive_out.oe                 = `HOST_PAD_OE;
    case (route_in)
      ROUTE_A: begin
        drive_out.out[7]    = func_out_in.audio_dout;
        drive_out.out[8]    = func_out_in.debug_txd;
        drive_out.oe[7]     = 1'b1;
        drive_out.oe[8]     = 1'b1;
        audio_din_pad_out   = 4'h6;
        debug_rxd_pad_out   = 4'h9;
        audio_clk_valid_out = 1'b1;
      end
      ROUTE_B: begin
        drive_out.out[7]    = func_out_in.audio_dout;
        drive_out.out[8]    = func_out_in.ext_receive_enable;
        drive_out.out[9]    = func_out_in.ext_amp_enable;
        drive_out.oe[9:7]   = 3'h7;
        audio_din_pad_out   = 4'h6;
        audio_clk_valid_out = 1'b1;
      end
      ROUTE_C: begin
        drive_out.out[5]    = func_out_in.audio_dout;
        drive_out.out[7]    = func_out_in.debug_txd;
        drive_out.out[8]    = func_out_in.ext_receive_enable;
        drive_out.out[9]    = func_out_in.ext_amp_enable;
        drive_out.oe[5]     = 1'b1;
        drive_out.oe[9:7]   = 3'h7;
        audio_din_pad_out   = 4'h6;
        audio_clk_valid_out = 1'b1;
      end
      ROUTE_D: begin
        drive_out.out[7]    = func_out_in.debug_txd;
        drive_out.out[8]    = func_out_in.ext_receive_enable;
        drive_out.out[9]    = func_out_in.ext_amp_enable;
        drive_out.oe[9:7]   = 3'h7;
        debug_rxd_pad_out   = 4'h6;
      end
      default: begin
        drive_out.oe = `HOST_PAD_OE;
      end
    endcase
  end

endmodule

// [rtl/io_switch_matrix.sv]
// IO switch matrix: routes functional signals onto twelve pads and the
// service-request pad. Assumes config select and enable come from host logic
// on sys_clk_in; pad inputs are asynchronous and are synchronised here.
// Functional notes
// - All pads undriven while chip reset asserted
// - Pads 0-4 always carry host link
// - Service-request pad is always an input
// - Pads 5-11 undriven until host enables
// - Config A: audio, debug serial, audio clocks
// - Config B: audio, receive/amp enables, clocks
// - Config C: audio out pad 5, debug, enables
// - Config D: debug serial and enables only
// - Amp and receive enables drive external parts
// - Audio clock and word select shared inputs
`timescale 1ns/1ps
`include "io_switch_matrix_map.svh"

module io_switch_matrix (
  // Clock and resets
  input  wire logic                                sys_clk_in,
  input  wire logic                                sys_rst_in,
  input  wire logic                                chip_reset_low_in,
  // Host command: configuration select
  input  wire logic [1:0]                          cfg_select_in,
  input  wire logic                                cfg_enable_in,
  // Functional outputs from internal units
  input  wire io_switch_matrix_pkg::func_out_type  func_out_in,
  // Pads
  input  wire logic [`PAD_COUNT-1:0]               muxed_pad_in,
  input  wire logic                                service_request_pad_in,
  output logic [`PAD_COUNT-1:0]                    muxed_pad_out,
  output logic [`PAD_COUNT-1:0]                    muxed_pad_oe_out,
  // Functional inputs to internal units
  output io_switch_matrix_pkg::func_in_type        func_in_out,
  output logic                                     route_locked_out
);
  import io_switch_matrix_pkg::*;

  // Whole module state, registered in one place
  typedef struct packed {
    logic [`PAD_COUNT-1:0] pad_s1;
    logic [`PAD_COUNT-1:0] pad_s2;
    logic                  srq_s1;
    logic                  srq_s2;
    logic                  rstn_s1;
    logic                  rstn_s2;
    route_type             route;
    pad_drive_type         drive;
    func_in_type           fin;
  } state_type;

  // Current and next state, route table results
  state_type    state;
  state_type    next_state;
  pad_drive_type table_drive;
  logic [3:0]   audio_din_pad;
  logic [3:0]   debug_rxd_pad;
  logic         audio_clk_valid;

  // Map two-bit code to route
  function automatic route_type code_to_route(input logic [1:0] code);
    case (code)
      `CFG_CODE_A: code_to_route = ROUTE_A;
      `CFG_CODE_B: code_to_route = ROUTE_B;
      `CFG_CODE_C: code_to_route = ROUTE_C;
      default:     code_to_route = ROUTE_D;
    endcase
  endfunction

  // Pick synchronised pad bit by index, zero for none
  function automatic logic pick_pad(input logic [`PAD_COUNT-1:0] pads, input logic [3:0] idx);
    pick_pad = (idx == 4'h0) ? 1'b0 : pads[idx];
  endfunction

  pad_route_table u_table (
    .route_in            (state.route),
    .func_out_in         (func_out_in),
    .drive_out           (table_drive),
    .audio_din_pad_out   (audio_din_pad),
    .debug_rxd_pad_out   (debug_rxd_pad),
    .audio_clk_valid_out (audio_clk_valid)
  );

  // Next state
  always_comb begin
    next_state         = state;
    // Two-stage synchronisers: pads, service request, chip reset
    next_state.pad_s1  = muxed_pad_in;
    next_state.pad_s2  = state.pad_s1;
    next_state.srq_s1  = service_request_pad_in;
    next_state.srq_s2  = state.srq_s1;
    next_state.rstn_s1 = chip_reset_low_in;
    next_state.rstn_s2 = state.rstn_s1;
    // First command after reset sets the route; later ones ignored until chip reset
    if (cfg_enable_in && state.route == ROUTE_DEFAULT) begin
      next_state.route = code_to_route(cfg_select_in);
    end
    // Route table drive and synchronised inputs, one cycle on
    next_state.drive = table_drive;
    next_state.fin.host_din                = state.pad_s2[`PAD_HOST_DIN];
    next_state.fin.host_clk                = state.pad_s2[`PAD_HOST_CLK];
    next_state.fin.host_link_select_n      = state.pad_s2[`PAD_HOST_SEL];
    next_state.fin.host_service_request_in = state.srq_s2;
    next_state.fin.audio_din               = pick_pad(state.pad_s2, audio_din_pad);
    next_state.fin.debug_rxd               = pick_pad(state.pad_s2, debug_rxd_pad);
    next_state.fin.audio_bit_clock         = audio_clk_valid & state.pad_s2[10];
    next_state.fin.audio_word_select       = audio_clk_valid & state.pad_s2[11];
    // Chip reset returns route and pad drive to default, pads undriven
    if (!state.rstn_s2) begin
      next_state.route    = ROUTE_DEFAULT;
      next_state.drive.oe = `PAD_OE_RESET;
      next_state.drive.out = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs; enables also gated by live reset sync for immediate tristate on chip reset
  assign muxed_pad_out    = state.drive.out;
  assign muxed_pad_oe_out = state.rstn_s2 ? state.drive.oe : `PAD_OE_RESET;
  assign func_in_out      = state.fin;
  assign route_locked_out = (state.route != ROUTE_DEFAULT);

  // Assertions
  reset_tristate_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !$past(chip_reset_low_in, 2) |-> muxed_pad_oe_out == 12'h000)
    else $error("pads driven during chip reset");
  out_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !state.rstn_s2 |=> muxed_pad_out == 12'h000)
    else $error("pad drive values kept through chip reset");
  host_outputs_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(state.rstn_s2)
    |-> muxed_pad_out[`PAD_HOST_DOUT] == $past(func_out_in.host_dout) &&
        muxed_pad_out[`PAD_HOST_INT] == $past(func_out_in.host_int))
    else $error("host link outputs not on their pads");
  host_inputs_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in, 3)
    |-> func_in_out.host_din == $past(muxed_pad_in[`PAD_HOST_DIN], 3) &&
        func_in_out.host_clk == $past(muxed_pad_in[`PAD_HOST_CLK], 3) &&
        func_in_out.host_link_select_n == $past(muxed_pad_in[`PAD_HOST_SEL], 3))
    else $error("host link inputs not taken from their pads");
  host_pads_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    state.rstn_s2 && $past(state.rstn_s2) |-> muxed_pad_oe_out[4:0] == 5'h11)
    else $error("host link pad enables wrong");
  srq_input_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(service_request_pad_in, 3) == func_in_out.host_service_request_in ||
    !$past(state.rstn_s2, 1) || $past(sys_rst_in, 3))
    else $error("service request path broken");
  default_tristate_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(state.route) == ROUTE_DEFAULT |-> muxed_pad_oe_out[11:5] == 7'h00)
    else $error("muxed pad driven before enable");

  // Pad routing per configuration
  cfg_a_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    state.rstn_s2 && $past(state.route) == ROUTE_A && $past(state.rstn_s2)
    |-> muxed_pad_oe_out[11:5] == 7'h0c && muxed_pad_out[8] == $past(func_out_in.debug_txd))
    else $error("config A routing wrong");
  cfg_b_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    state.rstn_s2 && $past(state.route) == ROUTE_B && $past(state.rstn_s2)
    |-> muxed_pad_oe_out[11:5] == 7'h1c && muxed_pad_out[9] == $past(func_out_in.ext_amp_enable))
    else $error("config B routing wrong");
  cfg_c_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    state.rstn_s2 && $past(state.route) == ROUTE_C && $past(state.rstn_s2)
    |-> muxed_pad_oe_out[11:5] == 7'h1d && muxed_pad_out[5] == $past(func_out_in.audio_dout))
    else $error("config C routing wrong");
  cfg_d_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    state.rstn_s2 && $past(state.route) == ROUTE_D && $past(state.rstn_s2)
    |-> muxed_pad_oe_out[11:5] == 7'h1c &&
        muxed_pad_out[8] == $past(func_out_in.ext_receive_enable))
    else $error("config D routing wrong");
  amp_enable_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $past(state.rstn_s2) && ($past(state.route) inside {ROUTE_B, ROUTE_C, ROUTE_D})
    |-> muxed_pad_out[9] == $past(func_out_in.ext_amp_enable) &&
        muxed_pad_out[8] == $past(func_out_in.ext_receive_enable))
    else $error("amplifier or receive enable not on its pad");

  // Input selection per configuration
  audio_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($past(state.route) inside {ROUTE_A, ROUTE_B, ROUTE_C})
    |-> func_in_out.audio_din == $past(state.pad_s2[6]) &&
        func_in_out.audio_bit_clock == $past(state.pad_s2[10]) &&
        func_in_out.audio_word_select == $past(state.pad_s2[11]))
    else $error("audio inputs not taken from their pads");
  audio_idle_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    ($past(state.route) inside {ROUTE_DEFAULT, ROUTE_D})
    |-> !func_in_out.audio_din && !func_in_out.audio_bit_clock &&
        !func_in_out.audio_word_select)
    else $error("audio inputs live while unrouted");
  debug_route_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    func_in_out.debug_rxd == ($past(state.route) == ROUTE_A ? $past(state.pad_s2[9]) :
      ($past(state.route) == ROUTE_D ? $past(state.pad_s2[6]) : 1'b0)))
    else $error("debug receive source wrong");

  // Route selection and lock
  route_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    route_locked_out && state.rstn_s2 |=> $stable(state.route) || !$past(state.rstn_s2))
    else $error("route changed without reset");
  select_take_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    cfg_enable_in && !route_locked_out && state.rstn_s2 |=> route_locked_out)
    else $error("config command not taken");
  route_clear_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !state.rstn_s2 |=> !route_locked_out)
    else $error("route kept through chip reset");
  select_code_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    cfg_enable_in && !route_locked_out && state.rstn_s2
    |=> (state.route == ROUTE_A) == ($past(cfg_select_in) == `CFG_CODE_A) &&
        (state.route == ROUTE_B) == ($past(cfg_select_in) == `CFG_CODE_B) &&
        (state.route == ROUTE_C) == ($past(cfg_select_in) == `CFG_CODE_C) &&
        (state.route == ROUTE_D) == ($past(cfg_select_in) == `CFG_CODE_D))
    else $error("config code mapped to wrong route");

  cover_cfg_a_c: cover property (@(posedge sys_clk_in) state.route == ROUTE_A);
  cover_cfg_b_c: cover property (@(posedge sys_clk_in) state.route == ROUTE_B);
  cover_cfg_c_c: cover property (@(posedge sys_clk_in) state.route == ROUTE_C);
  cover_cfg_d_c: cover property (@(posedge sys_clk_in) state.route == ROUTE_D);
  cover_relock_c: cover property (@(posedge sys_clk_in)
    route_locked_out ##1 !state.rstn_s2 ##[1:20] route_locked_out);

endmodule

// [tb/pad_far_side.sv]
// Far side of the pads: host link, audio, debug and amplifier parts.
// Assumes the bench supplies what each external part drives on its lines.
`timescale 1ns/1ps
`include "io_switch_matrix_map.svh"

module pad_far_side (
  // Pad drive from the device
  input  wire logic [`PAD_COUNT-1:0] pad_out_in,
  input  wire logic [`PAD_COUNT-1:0] pad_oe_in,
  // Values driven by the external parts
  input  wire logic [`PAD_COUNT-1:0] ext_drive_in,
  // Resolved pad levels
  output logic      [`PAD_COUNT-1:0] pad_level_out
);
  // Device wins where it drives, external parts drive the rest
  always_comb begin
    for (int i = 0; i < `PAD_COUNT; i++) begin
      pad_level_out[i] = pad_oe_in[i] ? pad_out_in[i] : ext_drive_in[i];
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the IO switch matrix with a reference model.
// Assumes the package and map header are compiled ahead of it.
`timescale 1ns/1ps
`include "io_switch_matrix_map.svh"

module testbench;
  import io_switch_matrix_pkg::*;
  logic                  sys_clk_in;
  logic                  sys_rst_in;
  logic                  chip_reset_low_in;
  logic                  cfg_enable_in;
  logic                  srq_pad;
  logic                  locked;
  logic [1:0]            cfg_select_in;
  func_out_type          fo;
  func_in_type           fi;
  func_in_type           ei;
  logic [`PAD_COUNT-1:0] ext_drive;
  logic [`PAD_COUNT-1:0] pad_level;
  logic [`PAD_COUNT-1:0] pad_out;
  logic [`PAD_COUNT-1:0] pad_oe;
  logic [`PAD_COUNT-1:0] eo;
  logic [`PAD_COUNT-1:0] ed;
  int                    n_fail;
  int                    tests_run;
  int                    route;

  io_switch_matrix io_switch_matrix_inst (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .chip_reset_low_in(chip_reset_low_in),
    .cfg_select_in(cfg_select_in), .cfg_enable_in(cfg_enable_in), .func_out_in(fo),
    .muxed_pad_in(pad_level), .service_request_pad_in(srq_pad), .muxed_pad_out(pad_out),
    .muxed_pad_oe_out(pad_oe), .func_in_out(fi), .route_locked_out(locked));

  pad_far_side pad_far_side_inst (
    .pad_out_in(pad_out), .pad_oe_in(pad_oe), .ext_drive_in(ext_drive),
    .pad_level_out(pad_level));

  // Clock generator
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reference routing for the current route (4 is default)
  task automatic model();
    eo = `HOST_PAD_OE;
    ed = '0;
    ei = '0;
    ed[0] = fo.host_dout;
    ed[4] = fo.host_int;
    ei.host_din = ext_drive[1];
    ei.host_clk = ext_drive[2];
    ei.host_link_select_n = ext_drive[3];
    ei.host_service_request_in = srq_pad;
    if (route < 3) begin
      ei.audio_din = ext_drive[6];
      ei.audio_bit_clock = ext_drive[10];
      ei.audio_word_select = ext_drive[11];
    end
    if (route == 0) begin
      eo[8:7] = 2'h3;
      ed[7] = fo.audio_dout;
      ed[8] = fo.debug_txd;
      ei.debug_rxd = ext_drive[9];
    end else if (route < 4) begin
      eo[9:7] = 3'h7;
      ed[7] = (route == 1) ? fo.audio_dout : fo.debug_txd;
      ed[8] = fo.ext_receive_enable;
      ed[9] = fo.ext_amp_enable;
      eo[5] = (route == 2);
      ed[5] = (route == 2) & fo.audio_dout;
      if (route == 3) begin
        ei.debug_rxd = ext_drive[6];
      end
    end
  endtask

  // Random traffic on all pads, compared once settled
  task automatic round(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
      fo = 6'($urandom);
      ext_drive = 12'($urandom);
      srq_pad = 1'($urandom);
      repeat (4) @(posedge sys_clk_in);
      #1;
      model();
      check(16'(pad_oe), 16'(eo));
      check(16'(pad_out & eo), 16'(ed));
      check(16'(fi), 16'(ei));
    end
  endtask

  // Host picks a configuration by one command strobe
  task automatic command(input int c);
    @(posedge sys_clk_in);
    #1;
    cfg_select_in = 2'(c);
    cfg_enable_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    cfg_enable_in = 1'b0;
  endtask

  // Chip reset pulse, then default routing
  task automatic chip_reset();
    @(posedge sys_clk_in);
    #1;
    chip_reset_low_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(16'(pad_oe), 16'h0000);
    chip_reset_low_in = 1'b1;
    route = 4;
    round(2);
    check(16'(locked), 16'h0000);
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    tests_run = 0;
    route = 4;
    sys_rst_in = 1'b1;
    chip_reset_low_in = 1'b1;
    cfg_enable_in = 1'b0;
    cfg_select_in = 2'h0;
    fo = '0;
    ext_drive = '0;
    srq_pad = 1'b0;
    void'($urandom(3484));
    repeat (20) @(posedge sys_clk_in);
    #1;
    check(16'(pad_oe), 16'h0000);
    sys_rst_in = 1'b0;
    round(2);
    for (int c = 0; c < 4; c++) begin
      chip_reset();
      command(c);
      route = c;
      round(3);
      check(16'(locked), 16'h0001);
      command((c + 1) % 4);
      round(2);
    end
    print_verdict();
  end

  // Watchdog against a hang
  initial begin
    #(25 * 5000);
    n_fail++;
    print_verdict();
  end
endmodule
